/* design/pvc_defs.vh */
// Offsets, field positions, constant values and timing for the capability bank
`ifndef PVC_DEFS_VH
`define PVC_DEFS_VH

`define PVC_CAP_PTR_OFS     8'h34
`define PVC_VPD_CAP_OFS     8'h44
`define PVC_VITAL_DATA_WORD_OFS    8'h48
`define PVC_PM_CAP_OFS      8'h4c
`define PVC_PM_CSR_OFS      8'h50

`define PVC_CAP_PTR_VAL     8'h44
`define PVC_VPD_CODE        8'h03
`define PVC_VPD_NEXT        8'h4c
`define PVC_PM_CODE         8'h01
`define PVC_PM_NEXT         8'h00
`define PVC_PM_CAP_HI       16'h0022

`define PVC_FLAG_BIT        31
`define PVC_PTR_LSB         16
`define PVC_PTR_W           8
`define PVC_STATE_D0        2'b00
`define PVC_STATE_D3HOT     2'b11

`define PVC_BIT_CLK_DIV     8'h7c
`define PVC_EE_DEV_WR       8'ha0
`define PVC_EE_DEV_RD       8'ha1
`define PVC_EE_WR_WAIT_NS   5000000
`define PVC_CLK_PERIOD_NS   10
`define PVC_EE_WR_WAIT_CYC  (`PVC_EE_WR_WAIT_NS / `PVC_CLK_PERIOD_NS)

`endif

/* design/pvc_eeprom_engine.v */
// Two-wire EEPROM engine moving at most one byte per call, start/stop framing
`timescale 1ns/100ps
`include "pvc_defs.vh"
module pvc_eeprom_engine (
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire       i_go,
    input  wire [1:0] i_kind,
    input  wire [7:0] i_tx,
    input  wire       i_ack_out,
    input  wire       i_sda_in,
    output reg        o_done,
    output reg  [7:0] o_rx,
    output reg        o_scl,
    output reg        o_sda_oe
);
    // kind: 0 start+byte, 1 byte, 2 read byte, 3 stop
    localparam IDLE = 2'd0;
    localparam RUN  = 2'd1;
    localparam FIN  = 2'd2;

    reg [1:0] state;
    reg [7:0] div;
    reg [5:0] phase;
    reg [1:0] kind;
    reg [8:0] shifter;
    wire      tick = (div == `PVC_BIT_CLK_DIV);
    wire      last = (kind == 2'd3) ? (phase == 6'd3) :
                     (kind == 2'd0) ? (phase == 6'd39) : (phase == 6'd35);

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            state    <= IDLE;
            div      <= 8'h00;
            phase    <= 6'd0;
            kind     <= 2'd0;
            shifter  <= 9'h000;
            o_done   <= 1'b0;
            o_rx     <= 8'h00;
            o_scl    <= 1'b1;
            o_sda_oe <= 1'b0;
        end else begin
            o_done <= 1'b0;
            div    <= tick ? 8'h00 : div + 8'h01;
            case (state)
            IDLE: begin
                if (i_go) begin
                    state   <= RUN;
                    kind    <= i_kind;
                    phase   <= 6'd0;
                    div     <= 8'h00;
                    shifter <= (i_kind == 2'd2) ? {8'hff, ~i_ack_out}
                                                : {i_tx, 1'b1};
                end
            end
            RUN: begin
                if (tick) begin
                    phase <= phase + 6'd1;
                    if (kind == 2'd3) begin
                        // Stop: data low, clock high, then data released
                        o_sda_oe <= (phase < 6'd2);
                        o_scl    <= (phase != 6'd0);
                    end else if (kind == 2'd0 && phase < 6'd4) begin
                        // Start: release both, then pull data low
                        o_scl    <= (phase < 6'd3);
                        o_sda_oe <= (phase >= 6'd2);
                    end else begin
                        // Four ticks per bit; data moves while clock low
                        case (phase[1:0])
                        2'd0: begin
                            o_scl    <= 1'b0;
                            o_sda_oe <= ~shifter[8];
                        end
                        2'd1: o_scl <= 1'b1;
                        2'd2: begin
                            // Ack slot of a read byte is not data
                            if (kind != 2'd2 || phase[5:2] != 4'd8)
                                o_rx <= {o_rx[6:0], i_sda_in};
                            shifter <= {shifter[7:0], 1'b1};
                        end
                        default: o_scl <= 1'b0;
                        endcase
                    end
                    if (last) state <= FIN;
                end
            end
            default: begin
                o_done <= 1'b1;
                state  <= IDLE;
            end
            endcase
        end
    end
endmodule

/* design/pvc_capability_bank.v */
// Configuration capability bank: vital data and power management
//
// Notes on behaviour
// - Read of four bytes done sets flag
// - Write of four bytes done clears flag
// - Byte pointer bits 30:16, low eight kept
// - Vital header code 03, next 4c
// - Four bytes, low byte at pointer
// - Wake source support reads zero
// - D1 and D2 support read zero
// - Init sequence needed reads one
// - Wake clock needed reads zero
// - Spec revision reads 010
// - Power code 01, next link 00
// - Power state reports and accepts D0/D3hot
// - Writes of D1 or D2 ignored
// - Report value, scale, selector read zero
// - Wake status and enable read zero
// - Bridge extension reads zero
// - Capabilities pointer reads 44
`timescale 1ns/100ps
`include "pvc_defs.vh"
module pvc_capability_bank (
    input  wire        I_CORE_CLK,
    input  wire        I_NRST,
    input  wire        I_CFG_WR,
    input  wire        I_CFG_RD,
    input  wire [7:0]  I_CFG_ADDR,
    input  wire [3:0]  I_CFG_BE,
    input  wire [31:0] I_CFG_WDATA,
    input  wire        I_EE_SDA_IN,
    output reg  [31:0] O_CFG_RDATA,
    output reg         O_CFG_RVALID,
    output reg         O_EE_SCL,
    output reg         O_EE_SDA_OUT,
    output reg         O_EE_SDA_OE,
    output reg  [1:0]  O_POWER_STATE,
    output reg         O_VPD_BUSY
);
    localparam S_IDLE  = 3'd0;
    localparam S_ADDR  = 3'd1;
    localparam S_RDSA  = 3'd2;
    localparam S_XFER  = 3'd3;
    localparam S_STOP  = 3'd4;
    localparam S_WAIT  = 3'd5;
    localparam S_DONE  = 3'd6;

    reg         vpd_transfer_flag;
    reg [7:0]   vpd_byte_pointer;
    reg [31:0]  vital_data_word;
    reg [1:0]   power_state_field;
    reg [2:0]   state;
    reg         is_write;
    reg [1:0]   byte_idx;
    reg         data_phase;
    reg         eng_go;
    reg [1:0]   eng_kind;
    reg [7:0]   eng_tx;
    reg         eng_ack;
    reg [22:0]  wait_cnt;
    reg [31:0]  next_rdata;
    wire        eng_done;
    wire [7:0]  eng_rx;
    wire        eng_scl;
    wire        eng_oe;
    wire        busy = (state != S_IDLE);
    wire        wr_vcap = I_CFG_WR && I_CFG_ADDR == `PVC_VPD_CAP_OFS;
    wire        wr_vdat = I_CFG_WR && I_CFG_ADDR == `PVC_VITAL_DATA_WORD_OFS;
    wire        wr_pcsr = I_CFG_WR && I_CFG_ADDR == `PVC_PM_CSR_OFS;
    wire        start_req = wr_vcap && I_CFG_BE[3] && !busy;

    pvc_eeprom_engine u_engine (
        .i_clk     (I_CORE_CLK),
        .i_nrst    (I_NRST),
        .i_go      (eng_go),
        .i_kind    (eng_kind),
        .i_tx      (eng_tx),
        .i_ack_out (eng_ack),
        .i_sda_in  (I_EE_SDA_IN),
        .o_done    (eng_done),
        .o_rx      (eng_rx),
        .o_scl     (eng_scl),
        .o_sda_oe  (eng_oe)
    );

    // Read mux: constant fields are wired, reserved bits fall out as zero
    always @* begin
        next_rdata = 32'h0000_0000;
        if (I_CFG_ADDR == `PVC_CAP_PTR_OFS) begin
            next_rdata = {24'h000000, `PVC_CAP_PTR_VAL};
        end else if (I_CFG_ADDR == `PVC_VPD_CAP_OFS) begin
            next_rdata = {vpd_transfer_flag, 7'h00, vpd_byte_pointer,
                          `PVC_VPD_NEXT, `PVC_VPD_CODE};
        end else if (I_CFG_ADDR == `PVC_VITAL_DATA_WORD_OFS) begin
            next_rdata = vital_data_word;
        end else if (I_CFG_ADDR == `PVC_PM_CAP_OFS) begin
            // Upper half: no wake, no D1/D2, init needed, rev 010
            next_rdata = {`PVC_PM_CAP_HI, `PVC_PM_NEXT,
                          `PVC_PM_CODE};
        end else if (I_CFG_ADDR == `PVC_PM_CSR_OFS) begin
            next_rdata = {30'h0000_0000,
                          power_state_field};
        end
    end

    always @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_CFG_RDATA   <= 32'h0000_0000;
            O_CFG_RVALID  <= 1'b0;
            O_EE_SCL      <= 1'b1;
            O_EE_SDA_OUT  <= 1'b0;
            O_EE_SDA_OE   <= 1'b0;
            O_POWER_STATE <= `PVC_STATE_D0;
            O_VPD_BUSY    <= 1'b0;
        end else begin
            O_CFG_RVALID  <= I_CFG_RD;
            if (I_CFG_RD) O_CFG_RDATA <= next_rdata;
            O_EE_SCL      <= eng_scl;
            O_EE_SDA_OUT  <= 1'b0;
            O_EE_SDA_OE   <= eng_oe;
            O_POWER_STATE <= power_state_field;
            // Busy shows on the cycle after the starting write
            O_VPD_BUSY    <= busy || start_req;
        end
    end

    // Power state: only D0 and D3hot codes are accepted
    always @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            power_state_field <= `PVC_STATE_D0;
        end else if (wr_pcsr && I_CFG_BE[0]) begin
            if (I_CFG_WDATA[1:0] == `PVC_STATE_D0 ||
                I_CFG_WDATA[1:0] == `PVC_STATE_D3HOT) begin
                power_state_field <= I_CFG_WDATA[1:0];
            end
        end
    end

    // Vital data sequencer; a write while busy is dropped (software polls)
    always @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            vpd_transfer_flag <= 1'b0;
            vpd_byte_pointer  <= 8'h00;
            vital_data_word          <= 32'h0000_0000;
            state             <= S_IDLE;
            is_write          <= 1'b0;
            byte_idx          <= 2'd0;
            data_phase        <= 1'b0;
            eng_go            <= 1'b0;
            eng_kind          <= 2'd0;
            eng_tx            <= 8'h00;
            eng_ack           <= 1'b0;
            wait_cnt          <= 23'd0;
        end else begin
            eng_go <= 1'b0;
            if (wr_vdat && !busy) begin
                if (I_CFG_BE[0]) vital_data_word[7:0]   <= I_CFG_WDATA[7:0];
                if (I_CFG_BE[1]) vital_data_word[15:8]  <= I_CFG_WDATA[15:8];
                if (I_CFG_BE[2]) vital_data_word[23:16] <= I_CFG_WDATA[23:16];
                if (I_CFG_BE[3]) vital_data_word[31:24] <= I_CFG_WDATA[31:24];
            end
            case (state)
            S_IDLE: begin
                // Upper lanes carry the start; only lane 2 pointer kept
                if (wr_vcap && I_CFG_BE[3]) begin
                    if (I_CFG_BE[2])
                        vpd_byte_pointer <= I_CFG_WDATA[23:16];
                    vpd_transfer_flag <= I_CFG_WDATA[`PVC_FLAG_BIT];
                    is_write <= I_CFG_WDATA[`PVC_FLAG_BIT];
                    byte_idx <= 2'd0;
                    data_phase <= 1'b0;
                    eng_go   <= 1'b1;
                    eng_kind <= 2'd0;
                    eng_tx   <= `PVC_EE_DEV_WR;
                    state    <= S_ADDR;
                end
            end
            S_ADDR: begin
                if (eng_done) begin
                    eng_go   <= 1'b1;
                    eng_kind <= 2'd1;
                    eng_tx   <= vpd_byte_pointer;
                    state    <= is_write ? S_XFER : S_RDSA;
                end
            end
            S_RDSA: begin
                if (eng_done) begin
                    eng_go   <= 1'b1;
                    eng_kind <= 2'd0;
                    eng_tx   <= `PVC_EE_DEV_RD;
                    state    <= S_XFER;
                end
            end
            S_XFER: begin
                // Each completion starts the next of four data bytes; the one after the fourth starts the stop
                // A flag, not the byte value, tells address from data
                if (eng_done) begin
                    if (!is_write && eng_kind == 2'd2) begin
                        vital_data_word[byte_idx*8 +: 8] <= eng_rx;
                    end
                    if (data_phase && byte_idx == 2'd3) begin
                        eng_go   <= 1'b1;
                        eng_kind <= 2'd3;
                        state    <= S_STOP;
                    end else begin
                        if (data_phase)
                            byte_idx <= byte_idx + 2'd1;
                        data_phase <= 1'b1;
                        eng_go   <= 1'b1;
                        eng_kind <= is_write ? 2'd1 : 2'd2;
                        eng_tx   <= vital_data_word[(data_phase ?
                                     byte_idx + 2'd1 : 2'd0)*8 +: 8];
                        // Last read byte is not acknowledged
                        eng_ack  <= data_phase ?
                                    (byte_idx != 2'd2) : 1'b1;
                    end
                end
            end
            S_STOP: begin
                if (eng_done) begin
                    wait_cnt <= 23'd0;
                    state    <= is_write ? S_WAIT : S_DONE;
                end
            end
            S_WAIT: begin
                // Hold off completion for the EEPROM internal write cycle
                wait_cnt <= wait_cnt + 23'd1;
                if (wait_cnt == `PVC_EE_WR_WAIT_CYC - 1) state <= S_DONE;
            end
            default: begin
                vpd_transfer_flag <= ~is_write;
                state             <= S_IDLE;
            end
            endcase
        end
    end
endmodule

/* verification/pvc_cap_chk.sv */
// Checker for the configuration port and EEPROM pins of the capability bank
`timescale 1ns/100ps
module pvc_cap_chk (
    input wire        I_CORE_CLK,
    input wire        I_NRST,
    input wire        I_CFG_WR,
    input wire        I_CFG_RD,
    input wire [7:0]  I_CFG_ADDR,
    input wire [3:0]  I_CFG_BE,
    input wire [31:0] I_CFG_WDATA,
    input wire        I_EE_SDA_IN,
    input wire [31:0] O_CFG_RDATA,
    input wire        O_CFG_RVALID,
    input wire        O_EE_SCL,
    input wire        O_EE_SDA_OUT,
    input wire        O_EE_SDA_OE,
    input wire [1:0]  O_POWER_STATE,
    input wire        O_VPD_BUSY
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    wire pm_wr = I_CFG_WR && I_CFG_ADDR == 8'h50 && I_CFG_BE[0];
    rvalid_pulse_a: assert property (I_CFG_RD |=> O_CFG_RVALID)
        else $error("read not answered");
    rvalid_cause_a: assert property (O_CFG_RVALID |-> $past(I_CFG_RD))
        else $error("read valid without read");
    cap_ptr_a: assert property (
        I_CFG_RD && I_CFG_ADDR == 8'h34 |=> O_CFG_RDATA == 32'h44)
        else $error("capability pointer wrong");
    pm_cap_a: assert property (
        I_CFG_RD && I_CFG_ADDR == 8'h4c |=> O_CFG_RDATA == 32'h00220001)
        else $error("power capability wrong");
    vpd_hdr_a: assert property (
        I_CFG_RD && I_CFG_ADDR == 8'h44 |=>
        O_CFG_RDATA[15:0] == 16'h4c03 && O_CFG_RDATA[30:24] == 7'h0)
        else $error("vital data header wrong");
    csr_ro_a: assert property (
        I_CFG_RD && I_CFG_ADDR == 8'h50 |=> O_CFG_RDATA[31:2] == 30'h0)
        else $error("power status fixed bits wrong");
    state_set_a: assert property (
        pm_wr && I_CFG_WDATA[1] == I_CFG_WDATA[0] |->
        ##2 O_POWER_STATE == $past(I_CFG_WDATA[1:0], 2))
        else $error("power state not taken");
    state_hold_a: assert property (
        pm_wr && (I_CFG_WDATA[1] ^ I_CFG_WDATA[0]) && !$past(I_CFG_WR)
        |=> $stable(O_POWER_STATE)[*2])
        else $error("power state changed on D1 or D2");
    busy_start_a: assert property (
        I_CFG_WR && I_CFG_ADDR == 8'h44 && I_CFG_BE[3] && !O_VPD_BUSY
        |=> O_VPD_BUSY)
        else $error("transfer did not start");
    idle_line_a: assert property (
        !O_VPD_BUSY && $past(!O_VPD_BUSY) |-> O_EE_SCL && !O_EE_SDA_OE)
        else $error("serial lines not idle");
    cover property (I_CFG_WR && I_CFG_ADDR == 8'h44 && I_CFG_WDATA[31]);
    cover property ($fell(O_VPD_BUSY));
    cover property (O_POWER_STATE == 2'b11);
endmodule

/* verification/pvc_ee_model.sv */
// Behavioural two-wire EEPROM; byte at address a holds a ^ 8'ha5
`timescale 1ns/100ps
module pvc_ee_model (
    input  wire i_scl,
    input  wire i_sda,
    output reg  o_sda_oe
);
    reg [7:0] sh;
    reg [7:0] ptr;
    reg [7:0] tx;
    reg [3:0] bitn;
    reg [3:0] nbyte;
    reg       rd;
    reg       txm;
    initial begin
        o_sda_oe = 1'b0;
        bitn = 4'h0;
        txm = 1'b0;
        ptr = 8'h00;
    end
    always @(negedge i_sda) begin
        if (i_scl === 1'b1) begin
            bitn = 4'h0;
            nbyte = 4'h0;
            rd = 1'b0;
            txm = 1'b0;
        end
    end
    always @(posedge i_scl) begin
        if (bitn < 4'h8)
            sh = {sh[6:0], i_sda};
        // A master nack ends sending so the stop is not blocked
        if (bitn == 4'h8 && txm && i_sda)
            txm = 1'b0;
        bitn = bitn + 4'h1;
    end
    always @(negedge i_scl) begin
        if (bitn == 4'h8) begin
            o_sda_oe = !txm;
            if (!txm && nbyte == 4'h0)
                rd = sh[0];
            if (!txm && nbyte == 4'h1 && !rd)
                ptr = sh;
            nbyte = nbyte + 4'h1;
        end else if (bitn == 4'h9) begin
            bitn = 4'h0;
            if (nbyte == 4'h1 && rd)
                txm = 1'b1;
            if (txm) begin
                tx = ptr ^ 8'ha5;
                ptr = ptr + 8'h01;
            end
            o_sda_oe = txm & !tx[7];
        end else if (txm && bitn != 4'h0) begin
            o_sda_oe = !tx[3'h7 - bitn[2:0]];
        end
    end
endmodule

/* verification/tb_top.sv */
// Testbench driving configuration cycles against the capability bank
`timescale 1ns/100ps
module tb_top;
    reg         clk;
    reg         nrst;
    reg         wr;
    reg         rd;
    reg  [7:0]  addr;
    reg  [3:0]  be;
    reg  [31:0] wdata;
    reg  [31:0] v;
    wire [31:0] rdata;
    wire        rvalid, scl, dut_oe, mdl_oe, busy;
    wire [1:0]  pstate;
    wire        sda = !(dut_oe | mdl_oe);
    integer     error_cnt, checks, n, k;
    pvc_capability_bank i_pvc_capability_bank (.I_CORE_CLK(clk),
        .I_NRST(nrst), .I_CFG_WR(wr), .I_CFG_RD(rd), .I_CFG_ADDR(addr),
        .I_CFG_BE(be), .I_CFG_WDATA(wdata), .I_EE_SDA_IN(sda),
        .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid), .O_EE_SCL(scl),
        .O_EE_SDA_OUT(), .O_EE_SDA_OE(dut_oe), .O_POWER_STATE(pstate),
        .O_VPD_BUSY(busy));
    pvc_ee_model i_pvc_ee_model (.i_scl(scl), .i_sda(sda), .o_sda_oe(mdl_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task cfg_wr(input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            @(negedge clk);
            wr = 1'b1;
            addr = a;
            be = b;
            wdata = d;
            @(negedge clk);
            wr = 1'b0;
        end
    endtask
    task cfg_rd(input [7:0] a, output [31:0] d);
        begin
            @(negedge clk);
            rd = 1'b1;
            addr = a;
            @(negedge clk);
            rd = 1'b0;
            n = 0;
            while (rvalid !== 1'b1 && n < 3) begin
                @(negedge clk);
                n = n + 1;
            end
            d = rdata;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin
            cfg_rd(a, v);
            chk(v, e);
        end
    endtask
    task give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
            if (error_cnt == 0 && checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // One read transfer and a little register traffic fit well inside this
    initial begin
        #800000;
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial begin
        error_cnt = 0;
        checks = 0;
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        be = 4'h0;
        wdata = 32'h0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        rchk(8'h34, 32'h00000044);
        rchk(8'h44, 32'h00004c03);
        rchk(8'h4c, 32'h00220001);
        rchk(8'h50, 32'h00000000);
        rchk(8'h54, 32'h00000000);
        cfg_wr(8'h4c, 4'hf, 32'hffffffff);
        rchk(8'h4c, 32'h00220001);
        cfg_wr(8'h50, 4'hf, 32'hffffffff);
        rchk(8'h50, 32'h00000003);
        chk({30'h0, pstate}, 32'h3);
        cfg_wr(8'h50, 4'hf, 32'h1);
        rchk(8'h50, 32'h3);
        cfg_wr(8'h50, 4'hf, 32'h2);
        rchk(8'h50, 32'h3);
        cfg_wr(8'h50, 4'he, 32'h0);
        rchk(8'h50, 32'h3);
        cfg_wr(8'h50, 4'h1, 32'h0);
        rchk(8'h50, 32'h0);
        cfg_wr(8'h50, 4'h1, 32'h2);
        rchk(8'h50, 32'h0);
        cfg_wr(8'h48, 4'hf, 32'hdeadbeef);
        rchk(8'h48, 32'hdeadbeef);
        // Pointer 0xfe makes the four bytes wrap past 0xff
        cfg_wr(8'h44, 4'hf, 32'h7ffe0000);
        chk({31'h0, busy}, 32'h1);
        rchk(8'h44, 32'h00fe4c03);
        cfg_wr(8'h48, 4'hf, 32'h12345678);
        cfg_wr(8'h44, 4'hf, 32'h00100000);
        k = 0;
        v = 32'h0;
        while (v[31] !== 1'b1 && k < 20000) begin
            cfg_rd(8'h44, v);
            k = k + 1;
        end
        chk(v, 32'h80fe4c03);
        rchk(8'h48, 32'ha4a55a5b);
        chk({31'h0, busy}, 32'h0);
        cfg_wr(8'h48, 4'hf, 32'hcafef00d);
        cfg_wr(8'h44, 4'hf, 32'h80100000);
        repeat (2000) @(negedge clk);
        rchk(8'h44, 32'h80104c03);
        chk({31'h0, busy}, 32'h1);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        chk({31'h0, busy}, 32'h0);
        rchk(8'h44, 32'h00004c03);
        give_verdict;
    end
endmodule
bind pvc_capability_bank pvc_cap_chk i_pvc_cap_chk (.I_CORE_CLK(I_CORE_CLK),
    .I_NRST(I_NRST), .I_CFG_WR(I_CFG_WR), .I_CFG_RD(I_CFG_RD),
    .I_CFG_ADDR(I_CFG_ADDR), .I_CFG_BE(I_CFG_BE), .I_CFG_WDATA(I_CFG_WDATA),
    .I_EE_SDA_IN(I_EE_SDA_IN), .O_CFG_RDATA(O_CFG_RDATA),
    .O_CFG_RVALID(O_CFG_RVALID), .O_EE_SCL(O_EE_SCL),
    .O_EE_SDA_OUT(O_EE_SDA_OUT), .O_EE_SDA_OE(O_EE_SDA_OE),
    .O_POWER_STATE(O_POWER_STATE), .O_VPD_BUSY(O_VPD_BUSY));
